// file: rtl/euart_rx_channel.v
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`include "euart_rx_defs.vh"
module euart_rx_channel #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk_i, // System clock
  input wire rst_i, // Asynchronous reset, active high
  input wire [17:0] avs_address_i, // Byte address
  input wire avs_read_i, // Read request
  input wire avs_write_i, // Write request
  input wire [31:0] avs_writedata_i, // Write data
  input wire [3:0] avs_byteenable_i, // Byte lanes
  output reg [31:0] avs_readdata_o, // Read data
  output reg avs_waitrequest_o, // Low for one cycle to answer
  input wire rx_i, // Serial line in
  output reg irq_o // Interrupt request
);

  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  // Matches an address to a register index
  function hit;
    input [17:0] addr;
    input [15:0] idx;
    begin
      hit = (addr[17:2] == idx);
    end
  endfunction

  reg [7:0] baud_high_q;
  reg [7:0] baud_low_q;
  reg port_en_q;
  reg [3:0] thr_q;
  reg global_en_q;
  reg rx_data_avail_irq_enable_q;
  reg rx_overflow_irq_enable_q;
  reg rx_underflow_irq_enable_q;
  reg frame_error_irq_enable_q;
  reg rx_data_avail_flag_q;
  reg rx_overflow_flag_q;
  reg rx_underflow_flag_q;
  reg frame_error_flag_q;
  reg rx_meta_q;
  reg rx_sync_q;
  reg [1:0] state_q;
  reg [15:0] cnt_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg push_q;
  reg frame_error_evt_q;
  reg [15:0] idle_cnt_q;
  reg [7:0] idle_bits_q;
  reg idle_hit_q;
  wire [15:0] divisor;
  wire req;
  wire take;
  wire wr_byte;
  wire pop;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [FIFO_AW:0] fill;
  wire [4:0] fill5;
  wire below_thr;
  wire [7:0] idle_target;
  wire [7:0] irq_rd;

  assign divisor = {baud_high_q, baud_low_q};
  assign req = avs_read_i || avs_write_i;
  assign take = req && !avs_waitrequest_o;
  assign wr_byte = take && avs_write_i && avs_byteenable_i[0];
  assign pop = take && avs_read_i && hit(avs_address_i, `IDX_DATA);
  assign fill5 = {{(4-FIFO_AW){1'b0}}, fill};
  assign below_thr = (fill5 < {1'b0, thr_q});
  assign idle_target = {thr_q, 4'h0}; // Threshold times 16 bit periods
  assign irq_rd = {global_en_q, 1'b0, rx_data_avail_flag_q, rx_overflow_flag_q,
                   rx_underflow_flag_q, 1'b0, frame_error_flag_q, 1'b0};

  // Bus answer: waitrequest drops one cycle after a request, then rises
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else if (req && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  // Read data latched while waitrequest is high; unmapped reads give zero
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      avs_readdata_o <= 32'h00000000;
    else if (avs_read_i && avs_waitrequest_o)
    begin
      if (hit(avs_address_i, `IDX_IRQ))
        avs_readdata_o <= {24'h000000, irq_rd};
      else if (hit(avs_address_i, `IDX_BAUD_HIGH))
        avs_readdata_o <= {24'h000000, baud_high_q};
      else if (hit(avs_address_i, `IDX_BAUD_LOW))
        avs_readdata_o <= {24'h000000, baud_low_q};
      else if (hit(avs_address_i, `IDX_CTRL))
        avs_readdata_o <= {24'h000000, port_en_q, 3'h0, thr_q};
      else if (hit(avs_address_i, `IDX_DATA))
        avs_readdata_o <= {24'h000000, fifo_out_valid ? fifo_out_data : 8'h00};
      else if (hit(avs_address_i, `IDX_LEVEL))
        avs_readdata_o <= {27'h0, fill5};
      else
        avs_readdata_o <= 32'h00000000;
    end
  end

  // Configuration and enable registers
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      baud_high_q <= `RST_BYTE;
      baud_low_q <= `RST_BAUD_LOW;
      port_en_q <= 1'b0;
      thr_q <= 4'h0;
      global_en_q <= 1'b0;
      rx_data_avail_irq_enable_q <= 1'b0;
      rx_overflow_irq_enable_q <= 1'b0;
      rx_underflow_irq_enable_q <= 1'b0;
      frame_error_irq_enable_q <= 1'b0;
    end
    else if (wr_byte)
    begin
      if (hit(avs_address_i, `IDX_BAUD_HIGH))
        baud_high_q <= avs_writedata_i[7:0];
      else if (hit(avs_address_i, `IDX_BAUD_LOW))
        baud_low_q <= avs_writedata_i[7:0];
      else if (hit(avs_address_i, `IDX_CTRL))
      begin
        port_en_q <= avs_writedata_i[`BIT_PORT_EN];
        thr_q <= avs_writedata_i[`THR_MSB:`THR_LSB];
      end
      else if (hit(avs_address_i, `IDX_IRQ))
      begin
        global_en_q <= avs_writedata_i[`BIT_GLOBAL_EN];
        rx_data_avail_irq_enable_q <= avs_writedata_i[`BIT_DATA_AVAIL];
        rx_overflow_irq_enable_q <= avs_writedata_i[`BIT_OVERFLOW];
        rx_underflow_irq_enable_q <= avs_writedata_i[`BIT_UNDERFLOW];
        frame_error_irq_enable_q <= avs_writedata_i[`BIT_FRAME_ERROR];
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data_avail_flag_q <= 1'b0;
      rx_overflow_flag_q <= 1'b0;
      rx_underflow_flag_q <= 1'b0;
      frame_error_flag_q <= 1'b0;
    end
    else
    begin
      if ((fill5 != 5'h00 && !below_thr) || (idle_hit_q && below_thr && fill5 != 5'h00))
        rx_data_avail_flag_q <= 1'b1;
      else if (wr_byte && hit(avs_address_i, `IDX_IRQ) && !avs_writedata_i[`BIT_DATA_AVAIL]
               && below_thr)
        rx_data_avail_flag_q <= 1'b0;
      if (push_q && !fifo_in_ready)
        rx_overflow_flag_q <= 1'b1;
      else if (!port_en_q)
        rx_overflow_flag_q <= 1'b0;
      else if (wr_byte && hit(avs_address_i, `IDX_IRQ) && !avs_writedata_i[`BIT_OVERFLOW])
        rx_overflow_flag_q <= 1'b0;
      if (pop && !fifo_out_valid)
        rx_underflow_flag_q <= 1'b1;
      else if (!port_en_q)
        rx_underflow_flag_q <= 1'b0;
      else if (wr_byte && hit(avs_address_i, `IDX_IRQ) && !avs_writedata_i[`BIT_UNDERFLOW])
        rx_underflow_flag_q <= 1'b0;
      if (frame_error_evt_q)
        frame_error_flag_q <= 1'b1;
      else if (wr_byte && hit(avs_address_i, `IDX_IRQ) && !avs_writedata_i[`BIT_FRAME_ERROR])
        frame_error_flag_q <= 1'b0;
    end
  end

  // Interrupt request gated by per-source and global enables
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= global_en_q &&
               ((rx_data_avail_flag_q && rx_data_avail_irq_enable_q) ||
               (rx_overflow_flag_q && rx_overflow_irq_enable_q) ||
               (rx_underflow_flag_q && rx_underflow_irq_enable_q) ||
               (frame_error_flag_q && frame_error_irq_enable_q));
  end

  // Line synchroniser
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else
    begin
      rx_meta_q <= rx_i;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Receiver: samples mid-bit, one bit lasts divisor clocks, 8N1 frame
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      push_q <= 1'b0;
      frame_error_evt_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      frame_error_evt_q <= 1'b0;
      if (!port_en_q)
        state_q <= ST_IDLE;
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (!rx_sync_q)
            begin
              state_q <= ST_START;
              cnt_q <= {1'b0, divisor[15:1]};
            end
          end
          ST_START:
          begin
            if (cnt_q == 16'h0000)
            begin
              state_q <= rx_sync_q ? ST_IDLE : ST_DATA;
              cnt_q <= divisor - 16'h0001;
              bit_q <= 3'h0;
            end
            else
              cnt_q <= cnt_q - 16'h0001;
          end
          ST_DATA:
          begin
            if (cnt_q == 16'h0000)
            begin
              shift_q <= {rx_sync_q, shift_q[7:1]};
              cnt_q <= divisor - 16'h0001;
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7)
                state_q <= ST_STOP;
            end
            else
              cnt_q <= cnt_q - 16'h0001;
          end
          default:
          begin
            if (cnt_q == 16'h0000)
            begin
              push_q <= 1'b1;
              frame_error_evt_q <= !rx_sync_q;
              state_q <= ST_IDLE;
            end
            else
              cnt_q <= cnt_q - 16'h0001;
          end
        endcase
      end
    end
  end

  // Idle timer counts whole bit periods while the line rests high
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idle_cnt_q <= 16'h0000;
      idle_bits_q <= 8'h00;
      idle_hit_q <= 1'b0;
    end
    else
    begin
      idle_hit_q <= 1'b0;
      if (!port_en_q || state_q != ST_IDLE || !rx_sync_q)
      begin
        idle_cnt_q <= 16'h0000;
        idle_bits_q <= 8'h00;
      end
      else if (idle_cnt_q >= divisor - 16'h0001)
      begin
        idle_cnt_q <= 16'h0000;
        if (idle_bits_q != 8'hff)
          idle_bits_q <= idle_bits_q + 8'h01;
        if (idle_bits_q == idle_target && thr_q != 4'h0)
          idle_hit_q <= 1'b1;
      end
      else
        idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end

  // Receive FIFO, flushed while the port is disabled
  rx_byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(!port_en_q),
    .in_valid_i(push_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(shift_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data),
    .level_o(fill)
  );

endmodule

// file: rtl/euart_rx_defs.vh
`ifndef EUART_RX_DEFS_VH
`define EUART_RX_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_IRQ 16'h00bf
`define IDX_BAUD_HIGH 16'ha0a1
`define IDX_BAUD_LOW 16'ha0a2
`define IDX_CTRL 16'ha0a3
`define IDX_DATA 16'ha0a4
`define IDX_LEVEL 16'ha0a5

// Interrupt register bit positions
`define BIT_GLOBAL_EN 7
`define BIT_DATA_AVAIL 5
`define BIT_OVERFLOW 4
`define BIT_UNDERFLOW 3
`define BIT_FRAME_ERROR 1

// Control register fields
`define BIT_PORT_EN 7
`define THR_LSB 0
`define THR_MSB 3

// Reset values
`define RST_BYTE 8'h00
`define RST_BAUD_LOW 8'h01

// Idle timeout is threshold times this many bit periods
`define IDLE_BITS_PER_THR 16

`endif

// file: rtl/rx_byte_fifo.v
`timescale 1ns/100ps
module rx_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i, // System clock
  input wire rst_i, // Asynchronous reset, active high
  input wire flush_i, // Synchronous empty
  input wire in_valid_i, // Write request
  output wire in_ready_o, // Space available
  input wire [WIDTH-1:0] in_data_i, // Write data
  output wire out_valid_o, // Data available
  input wire out_ready_i, // Read acknowledge
  output wire [WIDTH-1:0] out_data_o, // Head word
  output wire [AW:0] level_o // Words held
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;
  assign out_data_o = mem[rd_q];
  assign level_o = cnt_q;

  // Storage array
  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_q] <= in_data_i;
  end

  // Pointers and count
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else if (flush_i)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

// file: sim/euart_rx_channel_properties.sv
`timescale 1ns/100ps
`include "euart_rx_defs.vh"
module euart_rx_channel_properties #(
  parameter FIFO_DEPTH = 8
) (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire [17:0] avs_address_i, // Address
  input wire avs_read_i, // Read
  input wire avs_write_i, // Write
  input wire [31:0] avs_writedata_i, // Write data
  input wire [3:0] avs_byteenable_i, // Lanes
  input wire [31:0] avs_readdata_o, // Read data
  input wire avs_waitrequest_o, // Wait
  input wire rx_i, // Line
  input wire irq_o // Interrupt
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire [15:0] idx = avs_address_i[17:2];
  wire acc = !avs_waitrequest_o && (avs_read_i || avs_write_i);
  wire ra = acc && avs_read_i;
  wire wa = acc && avs_write_i && avs_byteenable_i[0];
  wire [7:0] wd = avs_writedata_i[7:0];
  wire [7:0] rd = avs_readdata_o[7:0];
  wire mapped = idx == `IDX_IRQ || (idx >= `IDX_BAUD_HIGH && idx <= `IDX_LEVEL);
  reg [7:0] bh_q;
  reg [7:0] ir_q;
  reg dis_q;
  // Shadows of the baud high and interrupt bytes and the port enable bit seen on the bus
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bh_q <= 8'h00;
      ir_q <= 8'h00;
      dis_q <= 1'b1;
    end
    else if (wa)
    begin
      if (idx == `IDX_BAUD_HIGH)
        bh_q <= wd;
      if (idx == `IDX_IRQ)
        ir_q <= wd;
      if (idx == `IDX_CTRL)
        dis_q <= !wd[7];
    end
  end
  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_gen_off;
    wa && idx == `IDX_IRQ && !wd[7];
  endsequence
  property p_answer;
    s_req |=> !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_baud;
    ra && idx == `IDX_BAUD_HIGH |-> avs_readdata_o == {24'h0, bh_q};
  endproperty
  a_baud: assert property (p_baud) else $error("baud high readback");
  property p_irq_rd;
    ra && idx == `IDX_IRQ |-> rd[7] == ir_q[7] && (rd & 8'h45) == 8'h00;
  endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("irq register read");
  property p_gate;
    irq_o |-> $past(ir_q[7] && (ir_q & 8'h3a) != 8'h00);
  endproperty
  a_gate: assert property (p_gate) else $error("irq without enable");
  property p_off;
    s_gen_off |-> ##2 !irq_o;
  endproperty
  a_off: assert property (p_off) else $error("irq after global off");
  property p_dis;
    ra && dis_q && idx == `IDX_IRQ |-> !rd[4];
  endproperty
  a_dis: assert property (p_dis) else $error("overflow while disabled");
  property p_lvl;
    ra && idx == `IDX_LEVEL |-> avs_readdata_o <= (dis_q ? 0 : FIFO_DEPTH);
  endproperty
  a_lvl: assert property (p_lvl) else $error("fill level range");
  property p_unmap;
    ra && !mapped |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule

// file: sim/tb_top.sv
`timescale 1ns/100ps
`include "euart_rx_defs.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [17:0] adr = 18'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h1;
  wire [31:0] rdata;
  wire wreq;
  wire rx;
  wire irq;
  integer n_errors = 0;
  integer n_compared = 0;
  integer seed = 70;
  integer dv = 16;
  integer i;
  integer k;
  logic [7:0] q;
  logic [7:0] b;
  logic [7:0] exp_q[$];
  always #5 clk_i = ~clk_i;
  euart_rx_channel #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_euart_rx_channel (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .rx_i(rx), .irq_o(irq));
  uart_line_model u_uart_line_model (.clk_i(clk_i), .line_o(rx));
  task results;
  begin
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
  begin
    n_compared = n_compared + 1;
    if (s !== e)
    begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: %h vs %h", $time, s, e);
    end
  end
  endtask
  // One bus access, held until waitrequest is sampled low
  task bus(input logic w, input logic [15:0] x, input logic [7:0] d);
    integer n;
  begin
    adr <= {x, 2'b00};
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    n = 0;
    @(posedge clk_i);
    while (wreq !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
    if (n == 20)
    begin
      chk(8'h00, 8'h01);
      results;
    end
  end
  endtask
  task rdreg(input logic [15:0] x, input logic [7:0] e);
  begin
    bus(1'b0, x, 8'h00);
    chk(q, e);
  end
  endtask
  // Random byte over the line; the model keeps at most eight
  task sendb(input logic stp);
  begin
    b = 8'($random(seed));
    u_uart_line_model.send(b, stp, dv);
    if (exp_q.size() < 8)
      exp_q.push_back(b);
    repeat (4) @(posedge clk_i);
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdreg(`IDX_BAUD_HIGH, 8'h00);
    rdreg(`IDX_IRQ, 8'h00);
    b = 8'($random(seed));
    bus(1'b1, `IDX_BAUD_HIGH, b);
    be <= 4'he;
    bus(1'b1, `IDX_BAUD_HIGH, ~b);
    be <= 4'h1;
    bus(1'b1, 16'h0010, 8'h55);
    rdreg(16'h0010, 8'h00);
    rdreg(`IDX_BAUD_HIGH, b);
    // Divisor 256 exercises the high byte of the bit period
    bus(1'b1, `IDX_BAUD_HIGH, 8'h01);
    bus(1'b1, `IDX_BAUD_LOW, 8'h00);
    dv = 256;
    bus(1'b1, `IDX_CTRL, 8'h82);
    bus(1'b1, `IDX_IRQ, 8'hb2);
    sendb(1'b1);
    rdreg(`IDX_DATA, exp_q.pop_front());
    bus(1'b1, `IDX_BAUD_HIGH, 8'h00);
    bus(1'b1, `IDX_BAUD_LOW, 8'h10);
    dv = 16;
    // One byte below threshold: flag after the idle timeout
    sendb(1'b1);
    k = 0;
    while (irq !== 1'b1 && k < 1000)
    begin
      @(posedge clk_i);
      k = k + 1;
    end
    chk({7'h00, k > 450 && k < 1000}, 8'h01);
    if (k == 1000)
      results;
    rdreg(`IDX_IRQ, 8'ha0);
    sendb(1'b1);
    bus(1'b1, `IDX_IRQ, 8'h92);
    rdreg(`IDX_IRQ, 8'ha0);
    for (i = 0; i < 2; i = i + 1)
      rdreg(`IDX_DATA, exp_q.pop_front());
    bus(1'b1, `IDX_IRQ, 8'h92);
    rdreg(`IDX_IRQ, 8'h80);
    chk({7'h00, irq}, 8'h00);
    // Bad stop bit: flag set, byte kept, cleared only by software
    sendb(1'b0);
    rdreg(`IDX_IRQ, 8'h82);
    chk({7'h00, irq}, 8'h01);
    rdreg(`IDX_DATA, exp_q.pop_front());
    rdreg(`IDX_IRQ, 8'h82);
    bus(1'b1, `IDX_IRQ, 8'hb0);
    rdreg(`IDX_IRQ, 8'h80);
    bus(1'b1, `IDX_IRQ, 8'hb2);
    // Fill past eight, drain, then read empty
    for (i = 0; i < 9; i = i + 1)
      sendb(1'b1);
    rdreg(`IDX_LEVEL, 8'h08);
    rdreg(`IDX_IRQ, 8'hb0);
    for (i = 0; i < 8; i = i + 1)
      rdreg(`IDX_DATA, exp_q.pop_front());
    rdreg(`IDX_DATA, 8'h00);
    rdreg(`IDX_IRQ, 8'hb8);
    bus(1'b1, `IDX_CTRL, 8'h02);
    rdreg(`IDX_IRQ, 8'ha0);
    rdreg(`IDX_LEVEL, 8'h00);
    bus(1'b1, `IDX_IRQ, 8'h3a);
    // Request register lags the enable by one edge; let it settle
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq}, 8'h00);
    results;
  end
endmodule
bind euart_rx_channel euart_rx_channel_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .rx_i(rx_i), .irq_o(irq_o));

// file: sim/uart_line_model.sv
`timescale 1ns/100ps
module uart_line_model (
  input wire logic clk_i, // Clock
  output logic line_o // Serial line, idle high
);
  initial line_o = 1'b1;
  // Start, eight bits LSB first, stop; stop level chosen by caller
  task send(input logic [7:0] b, input logic stp, input integer dv);
    integer i;
    logic [9:0] fr;
  begin
    fr = {stp, b, 1'b0};
    for (i = 0; i < 10; i = i + 1)
    begin
      line_o <= fr[i];
      repeat (dv) @(posedge clk_i);
    end
    line_o <= 1'b1;
  end
  endtask
endmodule
